// file: hdl/host_port_access_decode.sv
`timescale 1ns/1ps
module host_port_access_decode (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RESET_N_I,
    // host control pins
    input  wire logic        ADDR_LATCH_STROBE_N_I,
    input  wire logic        BYTE_HALF_IDENT_I,
    input  wire logic        ACCESS_SEL_LO_I,
    input  wire logic        ACCESS_SEL_HI_I,
    input  wire logic        PORT_SELECT_N_I,
    input  wire logic        DATA_STROBE_A_I,
    input  wire logic        DATA_STROBE_B_I,
    input  wire logic        HOST_DIR_I,
    output logic             PORT_READY_OUT_O,
    // host data bus, bit 7 msb
    input  wire logic [7:0]  HOST_BUS_I,
    output logic      [7:0]  HOST_BUS_O,
    output logic             HOST_BUS_OE_N_O,
    // internal write stream (pointer, data)
    output logic             WR_VALID_O,
    input  wire logic        WR_READY_I,
    output logic      [31:0] WR_WORD_O,
    // internal read word at the current pointer
    output logic      [15:0] RD_ADDR_O,
    input  wire logic [15:0] RD_DATA_I,
    // control word seen by the processor
    output logic      [15:0] CONTROL_O
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,   // no access in progress
        ST_ACCESS = 3'b010,   // strobe active, controls latched
        ST_BUSY   = 3'b100    // finishing internal part
    } phase_t;

    phase_t                         phase_reg, phase_next;
    host_port_pkg::access_t         acc_reg, acc_next;         // latched controls
    logic                           as_n_reg;                  // previous address strobe
    logic                           strobe_reg;                // previous combined strobe
    logic                           cs_n_reg;                  // previous select
    logic                           as_used_reg, as_used_next; // controls came from addr strobe
    host_port_pkg::access_t         as_acc_reg, as_acc_next;   // captured on addr strobe
    logic [15:0]                    control_reg, control_next;
    logic [15:0]                    pointer_reg, pointer_next;
    logic [15:0]                    latch_reg, latch_next;     // data latch word
    logic [7:0]                     first_reg, first_next;     // held first write byte
    logic [7:0]                     wr_byte_reg, wr_byte_next; // bus byte seen while strobe active
    logic [7:0]                     dout_reg, dout_next;
    logic                           oe_n_reg, oe_n_next;
    logic [3:0]                     busy_reg, busy_next;
    logic                           post_inc_reg, post_inc_next;
    logic                           push;
    logic                           buf_ready;
    logic                           strobe;        // combined data strobe, high = active
    logic                           active;        // select and strobe both active
    logic                           start;         // access begins this cycle
    logic                           finish;        // access ends this cycle
    logic                           msb_first;
    logic [15:0]                    rd_word;
    logic [15:0]                    wr_word;
    host_port_pkg::access_t         pins;

    // ------------------------------------------------------------
    // combine strobes and detect edges
    // ------------------------------------------------------------
    always_comb
    begin
        // exclusive-nor strobes: idle pair gives high, so active is its inverse
        strobe = ~(DATA_STROBE_A_I ~^ DATA_STROBE_B_I);
        active = strobe && !PORT_SELECT_N_I;
        // start on the later falling of select or strobe
        start  = active && !(strobe_reg && !cs_n_reg);
        finish = !active && strobe_reg && !cs_n_reg;
        pins   = '{sel: {ACCESS_SEL_HI_I, ACCESS_SEL_LO_I},
                   dir: HOST_DIR_I, second: BYTE_HALF_IDENT_I};
    end

    // ------------------------------------------------------------
    // access sequencing and word assembly
    // ------------------------------------------------------------
    always_comb
    begin
        phase_next    = phase_reg;
        acc_next      = acc_reg;
        as_used_next  = as_used_reg;
        as_acc_next   = as_acc_reg;
        control_next  = control_reg;
        pointer_next  = pointer_reg;
        latch_next    = latch_reg;
        first_next    = first_reg;
        wr_byte_next  = wr_byte_reg;
        dout_next     = dout_reg;
        oe_n_next     = 1'b1;
        busy_next     = busy_reg;
        post_inc_next = post_inc_reg;
        push          = 1'b0;
        // byte order bit, together with the identifier, picks the half
        msb_first     = !control_reg[host_port_pkg::BYTE_ORDER_POS];
        rd_word       = latch_reg;
        wr_word       = latch_reg;
        // capture controls on the address strobe falling edge
        if (as_n_reg && !ADDR_LATCH_STROBE_N_I)
        begin
            as_acc_next  = pins;
            as_used_next = 1'b1;
        end
        case (phase_reg)
            ST_IDLE:
            begin
                if (start)
                begin
                    // strobe/select capture when address strobe idle high
                    acc_next     = as_used_reg ? as_acc_reg : pins;
                    as_used_next = 1'b0;
                    phase_next   = ST_ACCESS;
                end
            end
            ST_ACCESS:
            begin
                // select the word by access type
                case (acc_reg.sel)
                    host_port_pkg::SEL_CONTROL:  rd_word = control_reg;
                    // pointer reached only from the host side
                    host_port_pkg::SEL_POINTER:  rd_word = pointer_reg;
                    default:                     rd_word = latch_reg;
                endcase
                // drive only while reading with strobe and select active
                if (acc_reg.dir && active)
                begin
                    oe_n_next = 1'b0;
                    dout_next = (acc_reg.second ^ msb_first) ? rd_word[15:8] : rd_word[7:0];
                end
                // write byte sampled while strobe stands; the host may change it on release
                if (!acc_reg.dir && active)
                    wr_byte_next = HOST_BUS_I;
                if (finish)
                begin
                    phase_next = ST_IDLE;
                    // first write byte held, second completes the word
                    if (!acc_reg.dir && !acc_reg.second)
                        first_next = wr_byte_reg;
                    else if (!acc_reg.dir)
                    begin
                        wr_word = msb_first ? {first_reg, wr_byte_reg} : {wr_byte_reg, first_reg};
                        case (acc_reg.sel)
                            host_port_pkg::SEL_CONTROL: control_next = wr_word;
                            host_port_pkg::SEL_POINTER: pointer_next = wr_word;
                            default:
                            begin
                                latch_next = wr_word;
                                if (acc_reg.sel == host_port_pkg::SEL_DATA_INC)
                                    pointer_next = pointer_reg + 16'h0001;
                                phase_next = ST_BUSY;
                                busy_next  = 4'(host_port_pkg::BUSY_CYCLES);
                            end
                        endcase
                    end
                    else if (acc_reg.sel[0])
                    begin
                        // data read completes, then selector 01 advances the pointer
                        // only the second byte ends the word, so only it advances
                        post_inc_next = acc_reg.second
                                        && (acc_reg.sel == host_port_pkg::SEL_DATA_INC);
                        phase_next    = ST_BUSY;
                        busy_next     = 4'(host_port_pkg::BUSY_CYCLES);
                    end
                end
            end
            ST_BUSY:
            begin
                if (busy_reg > 4'h1)
                    busy_next = busy_reg - 4'h1;
                else if (acc_reg.dir)
                begin
                    // post-increment then fetch the next word
                    pointer_next  = post_inc_reg ? pointer_reg + 16'h0001 : pointer_reg;
                    post_inc_next = 1'b0;
                    phase_next    = ST_IDLE;
                end
                else
                begin
                    push = 1'b1;
                    if (buf_ready)
                        phase_next = ST_IDLE;
                end
            end
            default: phase_next = ST_IDLE;
        endcase
        // read latch tracks memory at the pointer while idle
        if (phase_reg == ST_IDLE)
            latch_next = RD_DATA_I;
    end

    // registers only
    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            phase_reg    <= ST_IDLE;
            acc_reg      <= '0;
            as_acc_reg   <= '0;
            as_used_reg  <= 1'b0;
            as_n_reg     <= 1'b1;
            strobe_reg   <= 1'b0;
            cs_n_reg     <= 1'b1;
            control_reg  <= host_port_pkg::CONTROL_RESET;
            pointer_reg  <= host_port_pkg::POINTER_RESET;
            latch_reg    <= host_port_pkg::LATCH_RESET;
            first_reg    <= 8'h00;
            wr_byte_reg  <= 8'h00;
            dout_reg     <= 8'h00;
            oe_n_reg     <= 1'b1;
            busy_reg     <= 4'h0;
            post_inc_reg <= 1'b0;
        end
        else
        begin
            phase_reg    <= phase_next;
            acc_reg      <= acc_next;
            as_acc_reg   <= as_acc_next;
            as_used_reg  <= as_used_next;
            as_n_reg     <= ADDR_LATCH_STROBE_N_I;
            strobe_reg   <= strobe;
            cs_n_reg     <= PORT_SELECT_N_I;
            control_reg  <= control_next;
            pointer_reg  <= pointer_next;
            latch_reg    <= latch_next;
            first_reg    <= first_next;
            wr_byte_reg  <= wr_byte_next;
            dout_reg     <= dout_next;
            oe_n_reg     <= oe_n_next;
            busy_reg     <= busy_next;
            post_inc_reg <= post_inc_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // write words stall in busy when the buffer is full
    word_buffer #(.WIDTH(32)) word_buffer_inst (
        .clk_i       (CLK_I),
        .reset_n_i   (RESET_N_I),
        .in_valid_i  (push),
        .in_ready_o  (buf_ready),
        .in_data_i   ({pointer_reg, latch_reg}),
        .out_valid_o (WR_VALID_O),
        .out_ready_i (WR_READY_I),
        .out_data_o  (WR_WORD_O)
    );

    always_comb
    begin
        PORT_READY_OUT_O = PORT_SELECT_N_I || (phase_reg != ST_BUSY);
        HOST_BUS_O       = dout_reg;
        HOST_BUS_OE_N_O  = oe_n_reg;
        RD_ADDR_O        = pointer_reg;
        CONTROL_O        = control_reg;
    end
endmodule

// file: hdl/word_buffer.sv
`timescale 1ns/1ps
// two-entry buffer; a stalled receiver never loses a word
module word_buffer #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_reg [2];     // storage entries
    logic [WIDTH-1:0] mem_next [2];
    logic             wr_reg, wr_next; // write index
    logic             rd_reg, rd_next; // read index
    logic [1:0]       cnt_reg, cnt_next;
    logic             push, pop;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        in_ready_o  = (cnt_reg != 2'h2);
        out_valid_o = (cnt_reg != 2'h0);
        out_data_o  = mem_reg[rd_reg];
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        mem_next    = mem_reg;
        wr_next     = wr_reg;
        rd_next     = rd_reg;
        cnt_next    = cnt_reg;
        if (push)
        begin
            mem_next[wr_reg] = in_data_i;
            wr_next          = ~wr_reg;
        end
        if (pop)
            rd_next = ~rd_reg;
        if (push && !pop)
            cnt_next = cnt_reg + 2'h1;
        else if (pop && !push)
            cnt_next = cnt_reg - 2'h1;
    end

    // registers only
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_reg     <= 1'b0;
            rd_reg     <= 1'b0;
            cnt_reg    <= 2'h0;
        end
        else
        begin
            mem_reg <= mem_next;
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

// file: pkg/host_port_pkg.sv
// Contract
// - latch controls on address strobe fall
// - else latch on last select/strobe fall
// - byte order bit picks word half
// - selector 00 reaches control register
// - selector 01 read post-increments pointer
// - selector 01 write pre-increments pointer
// - selector 10 reaches address pointer
// - pointer reachable by host only
// - selector 11 data access, pointer unchanged
// - strobe already active: latch on select fall
// - eight-bit two-way host data bus
// - float data bus when not reading
// - data strobes combined by exclusive-nor
// - ready low while busy, high when deselected
package host_port_pkg;

    // ------------------------------------------------------------
    // access selector codes
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_CONTROL  = 2'h0;
    localparam logic [1:0] SEL_DATA_INC = 2'h1;
    localparam logic [1:0] SEL_POINTER  = 2'h2;
    localparam logic [1:0] SEL_DATA_FIX = 2'h3;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          BYTE_ORDER_POS = 0;       // byte order bit in control word
    localparam logic [15:0] CONTROL_RESET  = 16'h0000;
    localparam logic [15:0] POINTER_RESET  = 16'h0000;
    localparam logic [15:0] LATCH_RESET    = 16'h0000;

    // ------------------------------------------------------------
    // timing: internal completion time of a data access
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int BUSY_TIME_NS  = 40;
    localparam int BUSY_CYCLES   = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // latched access controls
    typedef struct packed {
        logic [1:0] sel;       // access selector
        logic       dir;       // high read, low write
        logic       second;    // byte identifier
    } access_t;

    // word handed to the internal side
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } mem_word_t;

endpackage

// file: tb/host_port_chk.sv
`timescale 1ns/1ps
module host_port_chk (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RESET_N_I,
    // host controls
    input  wire logic        PORT_SELECT_N_I,
    input  wire logic        DATA_STROBE_A_I,
    input  wire logic        DATA_STROBE_B_I,
    input  wire logic        ACCESS_SEL_HI_I,
    input  wire logic        ACCESS_SEL_LO_I,
    input  wire logic        HOST_DIR_I,
    input  wire logic        PORT_READY_OUT_O,
    input  wire logic        HOST_BUS_OE_N_O,
    // internal side
    input  wire logic        WR_VALID_O,
    input  wire logic        WR_READY_I,
    input  wire logic [31:0] WR_WORD_O,
    input  wire logic [15:0] RD_ADDR_O,
    input  wire logic [15:0] CONTROL_O
);
    // -----------------------------------
    // helper logic
    // -----------------------------------
    logic       act;           // selected with the strobe pair active
    logic [1:0] sel_reg;       // selector seen during the last access
    logic [1:0] sel_next;
    assign act = !PORT_SELECT_N_I && (DATA_STROBE_A_I ^ DATA_STROBE_B_I);
    // selector follows the pins only while an access is live
    always_comb sel_next = act ? {ACCESS_SEL_HI_I, ACCESS_SEL_LO_I} : sel_reg;
    always_ff @(posedge CLK_I)
    begin
        sel_reg <= RESET_N_I ? sel_next : 2'h3;
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // -----------------------------------
    // assertions
    // -----------------------------------
    a_ready_when_deselected: assert property (PORT_SELECT_N_I |-> PORT_READY_OUT_O)
        else $error("ready low while deselected");
    a_busy_bounded: assert property ($fell(PORT_READY_OUT_O) |-> ##[1:40] PORT_READY_OUT_O)
        else $error("ready stuck low");
    a_float_when_idle: assert property ((!act)[*3] |-> HOST_BUS_OE_N_O)
        else $error("bus driven while idle");
    a_drive_near_access: assert property (!HOST_BUS_OE_N_O |-> act || $past(act) || $past(act, 2))
        else $error("bus driven outside an access");
    a_write_no_drive: assert property (act && !HOST_DIR_I && $past(act, 2) |-> HOST_BUS_OE_N_O)
        else $error("bus driven during a write");
    a_read_drives_bus: assert property ($rose(act) && HOST_DIR_I && PORT_READY_OUT_O ##1 act[*3] |-> !HOST_BUS_OE_N_O)
        else $error("read byte not driven");
    a_stream_holds: assert property (WR_VALID_O && !WR_READY_I |=> WR_VALID_O && $stable(WR_WORD_O))
        else $error("stream word dropped under stall");
    a_fixed_keeps_ptr: assert property (act && $past(act) && {ACCESS_SEL_HI_I, ACCESS_SEL_LO_I} == 2'h3 |-> $stable(RD_ADDR_O))
        else $error("pointer moved on fixed access");
    a_control_source: assert property (!$stable(CONTROL_O) |-> sel_reg == 2'h0)
        else $error("control changed by another access");
endmodule
bind host_port_access_decode host_port_chk host_port_chk_inst (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .PORT_SELECT_N_I(PORT_SELECT_N_I),
    .DATA_STROBE_A_I(DATA_STROBE_A_I), .DATA_STROBE_B_I(DATA_STROBE_B_I),
    .ACCESS_SEL_HI_I(ACCESS_SEL_HI_I), .ACCESS_SEL_LO_I(ACCESS_SEL_LO_I),
    .HOST_DIR_I(HOST_DIR_I), .PORT_READY_OUT_O(PORT_READY_OUT_O),
    .HOST_BUS_OE_N_O(HOST_BUS_OE_N_O), .WR_VALID_O(WR_VALID_O), .WR_READY_I(WR_READY_I),
    .WR_WORD_O(WR_WORD_O), .RD_ADDR_O(RD_ADDR_O), .CONTROL_O(CONTROL_O));

// file: tb/mem_partner.sv
`timescale 1ns/1ps
// internal memory seen from the port: scrambled content, stallable write stream
module mem_partner (
    // clock
    input  wire logic        clk_i,
    // read side
    input  wire logic [15:0] rd_addr_i,
    output logic      [15:0] rd_data_o,
    // write stream
    input  wire logic        stall_i,
    output logic             wr_ready_o
);
    // content is a scramble of the address, so a wrong pointer shows at once
    assign rd_data_o = rd_addr_i ^ 16'h5a3c;
    // ready moves just after an edge, like a real slave; a stall backs words up
    always_ff @(posedge clk_i)
    begin
        wr_ready_o <= !stall_i;
    end
endmodule

// file: tb/test_host_port_access_decode.sv
`timescale 1ns/1ps
module test_host_port_access_decode;
    logic        clk, rst_n, ale_n, ident, sel_lo, sel_hi, cs_n, ds_a, ds_b, dir, rdy;
    logic        oe_n, wr_valid, wr_ready, stall, byte_order_bit;
    logic [7:0]  bus_h, bus_o, bus_w;     // host drive, device drive, resolved wire
    logic [31:0] wr_word;
    logic [15:0] rd_addr, rd_data, ctrl, ptr, w;
    logic [31:0] wr_exp[$];               // expected stream words
    logic [7:0]  rd_exp[$];               // expected read bytes
    int          error_cnt, cmp_count;
    event        rd_smp;
    // wire level: the device wins only while it enables its driver
    assign bus_w = oe_n ? bus_h : bus_o;
    host_port_access_decode host_port_access_decode_inst (
        .CLK_I(clk), .RESET_N_I(rst_n), .ADDR_LATCH_STROBE_N_I(ale_n),
        .BYTE_HALF_IDENT_I(ident), .ACCESS_SEL_LO_I(sel_lo), .ACCESS_SEL_HI_I(sel_hi),
        .PORT_SELECT_N_I(cs_n), .DATA_STROBE_A_I(ds_a), .DATA_STROBE_B_I(ds_b),
        .HOST_DIR_I(dir), .PORT_READY_OUT_O(rdy), .HOST_BUS_I(bus_w), .HOST_BUS_O(bus_o),
        .HOST_BUS_OE_N_O(oe_n), .WR_VALID_O(wr_valid), .WR_READY_I(wr_ready),
        .WR_WORD_O(wr_word), .RD_ADDR_O(rd_addr), .RD_DATA_I(rd_data), .CONTROL_O(ctrl));
    mem_partner mem_partner_inst (.clk_i(clk), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
        .stall_i(stall), .wr_ready_o(wr_ready));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one host byte; mode 1 address strobe, 2 strobe before select, 3 second strobe
    task automatic hbyte(input logic [1:0] s, input logic rd, input logic sec,
                         input logic [7:0] d, input int mode);
        @(negedge clk);
        {sel_hi, sel_lo} = s;
        dir = rd;
        ident = sec;
        bus_h = d;
        // other modes leave address strobe high
        if (mode == 1)
        begin
            // controls must come from the strobe fall, not from the pins later
            // address strobe leads select
            ale_n = 1'b0;
            @(negedge clk);
            {sel_hi, sel_lo} = s ^ 2'h1;
            ident = ~sec;
        end
        if (mode == 2)
        begin
            ds_a = 1'b0;
            @(negedge clk);
        end
        if (mode == 3)
            ds_b = 1'b0;
        else
            ds_a = 1'b0;
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        if (rd)
            -> rd_smp;
        // mode 3 keeps select low between bytes
        {cs_n, ds_a, ds_b, ale_n} = {(mode != 3), 3'h7};
        // a released bus shows the inverse, never the last value
        bus_h = ~d;
        @(negedge clk);
        // ready drops only while selected and busy, here after the second byte of a mode 3 data write
        check("ready", {31'h0, !(mode == 3 && sec)}, {31'h0, rdy});
        repeat (3) @(negedge clk);
    endtask
    // first byte carries the high half unless the byte order bit is set
    task automatic wword(input logic [1:0] s, input logic [15:0] v, input int mode);
        hbyte(s, 1'b0, 1'b0, byte_order_bit ? v[7:0] : v[15:8], mode);
        hbyte(s, 1'b0, 1'b1, byte_order_bit ? v[15:8] : v[7:0], mode);
    endtask
    task automatic rword(input logic [1:0] s, input logic [15:0] v);
        rd_exp.push_back(byte_order_bit ? v[7:0] : v[15:8]);
        rd_exp.push_back(byte_order_bit ? v[15:8] : v[7:0]);
        hbyte(s, 1'b1, 1'b0, 8'h00, 0);
        hbyte(s, 1'b1, 1'b1, 8'h00, 0);
    endtask
    // watcher: read bytes at the sampling point, stream words at each accept
    always @(rd_smp)
        check("read byte", {23'h0, 1'b0, rd_exp.pop_front()}, {23'h0, oe_n, bus_w});
    always @(posedge clk)
        if (rst_n && wr_valid === 1'b1 && wr_ready === 1'b1)
            check("stream word", wr_exp.size() ? wr_exp.pop_front() : 'x, wr_word);
    initial
    begin
        #50us;
        error_cnt++;
        complete_run();
    end
    initial
    begin
        {rst_n, ident, sel_lo, sel_hi, stall, byte_order_bit, bus_h} = '0;
        {ale_n, cs_n, ds_a, ds_b, dir} = 5'h1f;
        error_cnt = 0;
        cmp_count = 0;
        void'($urandom(32'h8349));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        check("control", 16'h0000, ctrl);
        check("pointer", 16'h0000, rd_addr);
        for (int b = 0; b < 2; b++)
        begin
            wword(2'h0, {15'h0, b[0]}, 0);
            byte_order_bit = b[0];
            check("control", {15'h0, byte_order_bit}, ctrl);
            rword(2'h0, {15'h0, byte_order_bit});
            ptr = 16'($urandom);
            wword(2'h2, ptr, b + 1);
            check("pointer", ptr, rd_addr);
            rword(2'h2, ptr);
            rword(2'h3, ptr ^ 16'h5a3c);
            check("pointer", ptr, rd_addr);
            rword(2'h1, ptr ^ 16'h5a3c);
            check("pointer", ptr + 16'h1, rd_addr);
            stall = 1'b1;
            w = 16'($urandom);
            wr_exp.push_back({ptr + 16'h2, w});
            wword(2'h1, w, 3 * b);
            wr_exp.push_back({ptr + 16'h2, ~w});
            wword(2'h3, ~w, 0);
            repeat (6) @(negedge clk);
            stall = 1'b0;
            repeat (6) @(negedge clk);
        end
        check("stream left", 32'h0, 32'(wr_exp.size()));
        complete_run();
    end
endmodule
